// ---- src/rx_av_output_formatter.sv ----
// receive output formatter: video stream, audio stream, sideband, control
`timescale 1ns/1ps
module rx_av_output_formatter
   import rx_av_pkg::*;
#(
   parameter int PPC         = 2,
   parameter int MAX_BPC     = 16,
   parameter int AUD_W       = 24,
   parameter bit HPD_ACT_LOW = 1'b0,
   parameter bit SRC_ACT_LOW = 1'b0,
   parameter bit REMAP_420   = 1'b1
) (
   input  wire logic                     i_clk,          // 40 MHz clock
   input  wire logic                     i_rst_n,        // whole block
   input  wire logic                     i_vid_rst_n,    // video path
   input  wire logic                     i_aud_rst_n,    // audio path
   input  wire logic [7:0]               i_addr,         // reg address
   input  wire logic [31:0]              i_wdata,        // reg wr data
   input  wire logic                     i_wr,           // write strobe
   input  wire logic                     i_rd,           // read strobe
   output logic      [31:0]              o_rdata,        // reg rd data
   output logic                          o_plug_present, // presence pin
   input  wire logic                     i_source_present, // source pin
   output logic                          o_irq,          // interrupt
   input  wire logic [1:0]               i_sideband_status_word, // sb
   input  wire logic                     i_sideband_status_valid, // sb
   output logic                          o_video_rst,    // native rst
   input  wire logic                     i_pix_valid,    // native valid
   output logic                          o_pix_ready,    // native ready
   input  wire logic [PPC*3*IN_BPC-1:0]  i_pix_data,     // native pixels
   input  wire logic                     i_pix_sof,      // frame start
   input  wire logic                     i_pix_eol,      // line end
   input  wire logic                     i_pix_field,    // odd field
   output logic                          o_vid_valid,    // stream valid
   input  wire logic                     i_vid_ready,    // stream ready
   output logic      [PPC*3*MAX_BPC-1:0] o_vid_data,     // stream data
   output logic                          o_vid_sof,      // stream sof
   output logic                          o_vid_eol,      // stream eol
   output logic                          o_vid_fid,      // field id
   input  wire logic                     i_aud_valid,    // packet valid
   output logic                          o_aud_ready,    // packet ready
   input  wire logic [7:0]               i_aud_type,     // packet type
   input  wire logic [AUD_W-1:0]         i_aud_sample,   // sample
   output logic                          o_audio_word_valid, // word valid
   input  wire logic                     i_audio_word_accept, // ready
   output logic      [AUD_W-1:0]         o_aud_data,     // audio word
   output logic      [3:0]               o_aud_chan      // channel id
);
   localparam int NCOMP = PPC * 3;

   // ---------------- register bus ----------------
   ctrl_t            ctrl_q;
   logic [EV_W-1:0]  event_q;
   logic [EV_W-1:0]  event_d;
   logic [EV_W-1:0]  evmask_q;
   logic [3:0]       achan_q;
   logic [31:0]      rdata_q;
   logic [31:0]      rdata_d;
   logic             irq_q;

   wire wr_ctrl   = i_wr && (i_addr == ADDR_CTRL);
   wire wr_event  = i_wr && (i_addr == ADDR_EVENT);
   wire wr_evmask = i_wr && (i_addr == ADDR_EVMASK);
   wire wr_achan  = i_wr && (i_addr == ADDR_ACHAN);

   // ---------------- sideband and source present ----------------
   logic [3:0]  sb_meta_q;
   logic [3:0]  sb_sync_q;
   sideband_t   sb_q;
   logic        src_q;
   logic [EV_W-1:0] stat_prev_q;
   logic [EV_W-1:0] stat_now;

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         sb_meta_q <= 4'h0;
         sb_sync_q <= 4'h0;
      end else begin
         sb_meta_q <= {i_source_present, i_sideband_status_valid,
                       i_sideband_status_word};
         sb_sync_q <= sb_meta_q;
      end
   end

   // source present normalised to active high
   wire src_asserted = sb_sync_q[3] ^ SRC_ACT_LOW;

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         sb_q  <= '0;
         src_q <= 1'b0;
      end else begin
         if (sb_sync_q[2])
            sb_q <= sideband_t'(sb_sync_q[1:0]);
         src_q <= src_asserted;
      end
   end

   assign stat_now = {src_q, sb_q.video_rdy, sb_q.link_rdy};
   wire [EV_W-1:0] stat_chg = stat_now ^ stat_prev_q;

   // sticky change events; a new event beats a clearing write
   assign event_d = (event_q & ~(wr_event ? i_wdata[EV_W-1:0] : '0))
                    | stat_chg;

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         stat_prev_q <= '0;
         event_q     <= '0;
         irq_q       <= 1'b0;
      end else begin
         stat_prev_q <= stat_now;
         event_q     <= event_d;
         irq_q       <= |(event_d & evmask_q);
      end
   end
   assign o_irq = irq_q;

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         ctrl_q   <= ctrl_t'(CTRL_RST);
         evmask_q <= '0;
         achan_q  <= ACHAN_RST;
         rdata_q  <= 32'h0000_0000;
      end else begin
         if (wr_ctrl)
            ctrl_q <= ctrl_t'(i_wdata[7:0]);
         if (wr_evmask)
            evmask_q <= i_wdata[EV_W-1:0];
         if (wr_achan)
            achan_q <= i_wdata[3:0];
         rdata_q <= rdata_d;
      end
   end

   always_comb begin
      rdata_d = 32'h0000_0000;
      if (i_rd) begin
         case (i_addr)
            ADDR_CTRL:   rdata_d[7:0]      = ctrl_q;
            ADDR_STATUS: rdata_d[EV_W-1:0] = stat_now;
            ADDR_EVENT:  rdata_d[EV_W-1:0] = event_q;
            ADDR_EVMASK: rdata_d[EV_W-1:0] = evmask_q;
            ADDR_ACHAN:  rdata_d[3:0]      = achan_q;
            default:     rdata_d           = 32'h0000_0000;
         endcase
      end
   end
   assign o_rdata = rdata_q;

   // plug presence drive level
   assign o_plug_present = ctrl_q.hpd ^ HPD_ACT_LOW;

   // native video reset, registered, high while held by software
   logic video_rst_q;
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n)
         video_rst_q <= 1'b1;
      else
         video_rst_q <= ctrl_q.vid_rst;
   end
   assign o_video_rst = video_rst_q;

   // ---------------- video stream path ----------------
   wire vid_rst_n = i_rst_n & i_vid_rst_n;

   logic                     vvalid_q;
   logic [NCOMP*MAX_BPC-1:0] vdata_q;
   logic                     vsof_q;
   logic                     veol_q;
   logic                     vfid_q;
   logic                     line_odd_q;
   logic [NCOMP*MAX_BPC-1:0] vdata_d;

   // single output stage, no line storage
   wire vslot_free = !vvalid_q || i_vid_ready;
   wire vtake      = i_pix_valid && vslot_free;
   assign o_pix_ready = vslot_free;

   // 4:2:2 forced to 12 bit depth
   wire [1:0] eff_bpc = (ctrl_q.cfmt == CFMT_422) ? BPC_12 :
                        ctrl_q.bpc;
   // line parity restarts on each frame
   wire cur_odd = i_pix_sof ? 1'b0 : line_odd_q;
   wire drop_chroma = REMAP_420 && ctrl_q.remap_en &&
                      (ctrl_q.cfmt == CFMT_420) && cur_odd;

   genvar g;
   generate
      for (g = 0; g < NCOMP; g++) begin : g_comp
         logic [MAX_BPC-1:0] aligned;
         depth_align #(
            .MAX_BPC (MAX_BPC)
         ) u_align (
            .i_comp (i_pix_data[g*IN_BPC +: IN_BPC]),
            .i_bpc  (eff_bpc),
            .o_comp (aligned)
         );
         // components 1 and 2 of each pixel are chroma
         assign vdata_d[g*MAX_BPC +: MAX_BPC] =
            (drop_chroma && ((g % 3) != 0)) ? '0 : aligned;
      end
   endgenerate

   always_ff @(posedge i_clk or negedge vid_rst_n) begin
      if (!vid_rst_n) begin
         vvalid_q   <= 1'b0;
         vdata_q    <= '0;
         vsof_q     <= 1'b0;
         veol_q     <= 1'b0;
         vfid_q     <= 1'b0;
         line_odd_q <= 1'b0;
      end else begin
         if (vtake) begin
            vvalid_q   <= 1'b1;
            vdata_q    <= vdata_d;
            vsof_q     <= i_pix_sof;
            veol_q     <= i_pix_eol;
            vfid_q     <= ctrl_q.interlaced && i_pix_field;
            line_odd_q <= i_pix_eol ? !cur_odd : cur_odd;
         end else if (i_vid_ready) begin
            vvalid_q <= 1'b0;
         end
      end
   end

   assign o_vid_valid = vvalid_q;
   assign o_vid_data  = vdata_q;
   assign o_vid_sof   = vsof_q;
   assign o_vid_eol   = veol_q;
   assign o_vid_fid   = vfid_q;

   // ---------------- audio stream path ----------------
   wire aud_rst_n = i_rst_n & i_aud_rst_n;

   logic             avalid_q;
   logic [AUD_W-1:0] adata_q;
   logic [3:0]       achan_id_q;
   logic [3:0]       next_chan_q;

   wire type_ok    = (i_aud_type == PKT_LPCM) ||
                     (i_aud_type == PKT_HBR);
   wire aslot_free = !avalid_q || i_audio_word_accept;
   wire atake      = i_aud_valid && type_ok && aslot_free;
   // other packet types are consumed and discarded
   assign o_aud_ready = !type_ok || aslot_free;
   wire last_chan  = (next_chan_q >= achan_q - 4'h1) ||
                     (achan_q == 4'h0);

   always_ff @(posedge i_clk or negedge aud_rst_n) begin
      if (!aud_rst_n) begin
         avalid_q    <= 1'b0;
         adata_q     <= '0;
         achan_id_q  <= 4'h0;
         next_chan_q <= 4'h0;
      end else begin
         if (atake) begin
            avalid_q    <= 1'b1;
            adata_q     <= i_aud_sample;
            achan_id_q  <= next_chan_q;
            next_chan_q <= last_chan ? 4'h0 :
                           next_chan_q + 4'h1;
         end else if (i_audio_word_accept) begin
            avalid_q <= 1'b0;
         end
      end
   end

   assign o_audio_word_valid = avalid_q;
   assign o_aud_data         = adata_q;
   assign o_aud_chan         = achan_id_q;
endmodule

// ---- src/rx_av_pkg.sv ----
// shared constants and types for the receive output formatter
package rx_av_pkg;
   // register byte addresses
   localparam logic [7:0] ADDR_CTRL   = 8'h00;
   localparam logic [7:0] ADDR_STATUS = 8'h04;
   localparam logic [7:0] ADDR_EVENT  = 8'h08;
   localparam logic [7:0] ADDR_EVMASK = 8'h0C;
   localparam logic [7:0] ADDR_ACHAN  = 8'h10;
   // control register layout, low byte
   typedef struct packed {
      logic [1:0] bpc;
      logic [1:0] cfmt;
      logic       interlaced;
      logic       remap_en;
      logic       vid_rst;
      logic       hpd;
   } ctrl_t;
   localparam logic [7:0] CTRL_RST = 8'h02;
   // colour formats and actual depth codes
   localparam logic [1:0] CFMT_RGB = 2'h0;
   localparam logic [1:0] CFMT_444 = 2'h1;
   localparam logic [1:0] CFMT_422 = 2'h2;
   localparam logic [1:0] CFMT_420 = 2'h3;
   localparam logic [1:0] BPC_8  = 2'h0;
   localparam logic [1:0] BPC_10 = 2'h1;
   localparam logic [1:0] BPC_12 = 2'h2;
   localparam logic [1:0] BPC_16 = 2'h3;
   localparam int         IN_BPC = 16;
   // audio packet types carried to the audio output
   localparam logic [7:0] PKT_LPCM = 8'h02;
   localparam logic [7:0] PKT_HBR  = 8'h09;
   localparam logic [3:0] ACHAN_RST = 4'h2;
   // sideband word bit positions and event bits
   typedef struct packed {
      logic video_rdy;
      logic link_rdy;
   } sideband_t;
   localparam int EV_LINK = 0;
   localparam int EV_VID  = 1;
   localparam int EV_SRC  = 2;
   localparam int EV_W    = 3;
endpackage

// ---- src/depth_align.sv ----
// one component: msb-align to the output depth, truncate or zero pad
`timescale 1ns/1ps
module depth_align
   import rx_av_pkg::*;
#(
   parameter int MAX_BPC = 12
) (
   input  wire logic [IN_BPC-1:0]  i_comp, // lsb-aligned component
   input  wire logic [1:0]         i_bpc,  // actual depth code
   output logic      [MAX_BPC-1:0] o_comp  // msb-aligned result
);
   logic [IN_BPC-1:0] msb_al;
   always_comb begin
      case (i_bpc)
         BPC_8:   msb_al = {i_comp[7:0], 8'h00};
         BPC_10:  msb_al = {i_comp[9:0], 6'h00};
         BPC_12:  msb_al = {i_comp[11:0], 4'h0};
         default: msb_al = i_comp;
      endcase
   end
   // top bits kept, dropped low bits gone, short inputs zero padded
   assign o_comp = msb_al[IN_BPC-1 -: MAX_BPC];
endmodule

// ---- dv/rx_av_output_formatter_properties.sv ----
// port assertions for the receive output formatter
`timescale 1ns/1ps
module rx_av_output_formatter_properties
   import rx_av_pkg::*;
#(
   parameter int PPC         = 2,
   parameter int MAX_BPC     = 16,
   parameter int AUD_W       = 24,
   parameter bit HPD_ACT_LOW = 1'b0
) (
   input wire logic                     i_clk,
   input wire logic                     i_rst_n,
   input wire logic                     i_vid_rst_n,
   input wire logic                     i_aud_rst_n,
   input wire logic [7:0]               i_addr,
   input wire logic [31:0]              i_wdata,
   input wire logic                     i_wr,
   input wire logic                     o_plug_present,
   input wire logic                     o_video_rst,
   input wire logic                     i_pix_valid,
   input wire logic                     o_pix_ready,
   input wire logic                     i_pix_field,
   input wire logic                     o_vid_valid,
   input wire logic                     i_vid_ready,
   input wire logic [PPC*3*MAX_BPC-1:0] o_vid_data,
   input wire logic                     o_vid_fid,
   input wire logic                     i_aud_valid,
   input wire logic                     o_aud_ready,
   input wire logic [7:0]               i_aud_type,
   input wire logic [AUD_W-1:0]         i_aud_sample,
   input wire logic                     o_audio_word_valid,
   input wire logic                     i_audio_word_accept,
   input wire logic [AUD_W-1:0]         o_aud_data
);
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (!i_rst_n);
   chk_plug_level: assert property (i_wr && i_addr == ADDR_CTRL |=>
      o_plug_present == ($past(i_wdata[0]) ^ HPD_ACT_LOW))
      else $error("plug output does not follow control write");
   chk_vrst_follow: assert property (i_wr && i_addr == ADDR_CTRL |->
      ##2 o_video_rst == $past(i_wdata[1], 2))
      else $error("video reset output does not follow control");
   chk_pix_ready: assert property (o_pix_ready ==
      (!o_vid_valid || i_vid_ready))
      else $error("pixel ready wrong for output stage state");
   chk_vid_take: assert property (disable iff (!i_rst_n || !i_vid_rst_n)
      i_pix_valid && o_pix_ready |=> o_vid_valid)
      else $error("taken pixel beat not offered next cycle");
   chk_vid_fid: assert property (disable iff (!i_rst_n || !i_vid_rst_n)
      i_pix_valid && o_pix_ready && !i_pix_field |=> !o_vid_fid)
      else $error("field id high for an even or progressive beat");
   chk_vid_hold: assert property (disable iff (!i_rst_n || !i_vid_rst_n)
      o_vid_valid && !i_vid_ready |=> o_vid_valid && $stable(o_vid_data))
      else $error("video word changed while stalled");
   chk_aud_hold: assert property (disable iff (!i_rst_n || !i_aud_rst_n)
      o_audio_word_valid && !i_audio_word_accept |=>
      o_audio_word_valid && $stable(o_aud_data))
      else $error("audio word changed while stalled");
   chk_aud_take: assert property (disable iff (!i_rst_n || !i_aud_rst_n)
      i_aud_valid && o_aud_ready &&
      (i_aud_type == PKT_LPCM || i_aud_type == PKT_HBR) |=>
      o_audio_word_valid && o_aud_data == $past(i_aud_sample))
      else $error("audio packet sample not offered next cycle");
endmodule
bind rx_av_output_formatter rx_av_output_formatter_properties #(
   .PPC(PPC), .MAX_BPC(MAX_BPC), .AUD_W(AUD_W), .HPD_ACT_LOW(HPD_ACT_LOW)
) u_props (.*);

// ---- dv/av_stream_sink.sv ----
// downstream sink: optional stalls, keeps the last accepted words
`timescale 1ns/1ps
module av_stream_sink #(
   parameter int VW = 73,
   parameter int AW = 24
) (
   input  wire logic          i_clk,       // stream clock
   input  wire logic          i_slow,      // stall every other cycle
   input  wire logic          i_vid_valid, // video word offered
   input  wire logic [VW-1:0] i_vid_data,  // video word
   output logic               o_vid_ready, // video accept
   input  wire logic          i_aud_valid, // audio word offered
   input  wire logic [AW-1:0] i_aud_data,  // audio sample
   input  wire logic [3:0]    i_aud_chan,  // channel id
   output logic               o_aud_ready, // audio accept
   output logic [VW-1:0]      o_vid_got,   // last video taken
   output logic [AW+3:0]      o_aud_got,   // last chan and sample
   output int                 o_n_vid,     // video words taken
   output int                 o_n_aud      // audio words taken
);
   logic ph     = 1'b0;
   logic vrdy_q = 1'b0;
   logic ardy_q = 1'b0;
   int   nvid_q = 0;
   int   naud_q = 0;
   always @(posedge i_clk) begin
      ph     <= ~ph;
      vrdy_q <= !i_slow || ph;
      ardy_q <= !i_slow || !ph;
      if (i_vid_valid && vrdy_q) begin
         o_vid_got <= i_vid_data;
         nvid_q    <= nvid_q + 1;
      end
      if (i_aud_valid && ardy_q) begin
         o_aud_got <= {i_aud_chan, i_aud_data};
         naud_q    <= naud_q + 1;
      end
   end
   assign o_vid_ready = vrdy_q;
   assign o_aud_ready = ardy_q;
   assign o_n_vid     = nvid_q;
   assign o_n_aud     = naud_q;
endmodule

// ---- dv/test_rx_av_output_formatter.sv ----
// self-checking bench for the receive output formatter
`timescale 1ns/1ps
module test_rx_av_output_formatter;
   import rx_av_pkg::*;
   logic i_clk = 0, i_rst_n = 0, i_vid_rst_n = 0, i_aud_rst_n = 0, slow = 0;
   logic i_wr = 0, i_rd = 0, i_source_present = 1, i_aud_valid = 0;
   logic i_sideband_status_valid = 0, i_pix_valid = 0, i_pix_sof = 0;
   logic i_pix_eol = 0, i_pix_field = 0, o_plug_present, o_irq, o_video_rst;
   logic o_pix_ready, o_vid_valid, i_vid_ready, o_vid_sof, o_vid_eol;
   logic o_vid_fid, o_aud_ready, o_audio_word_valid, i_audio_word_accept;
   logic [7:0]  i_addr = '0, i_aud_type = '0;
   logic [31:0] i_wdata = '0, o_rdata;
   logic [1:0]  i_sideband_status_word = '0;
   logic [95:0] i_pix_data = '0;
   logic [71:0] o_vid_data;
   logic [74:0] vid_got;
   logic [23:0] i_aud_sample = '0, o_aud_data;
   logic [27:0] aud_got;
   logic [3:0]  o_aud_chan;
   int err_count = 0, n_compared = 0, n_vid, n_aud, cyc = 0;
   rx_av_output_formatter #(.MAX_BPC(12)) u_dut (.*);
   av_stream_sink #(.VW(75)) u_sink (.i_clk(i_clk), .i_slow(slow),
      .i_vid_valid(o_vid_valid),
      .i_vid_data({o_vid_sof, o_vid_eol, o_vid_fid, o_vid_data}),
      .o_vid_ready(i_vid_ready), .i_aud_valid(o_audio_word_valid),
      .i_aud_data(o_aud_data), .i_aud_chan(o_aud_chan),
      .o_aud_ready(i_audio_word_accept), .o_vid_got(vid_got),
      .o_aud_got(aud_got), .o_n_vid(n_vid), .o_n_aud(n_aud));
   initial begin
      forever #12.5 i_clk = ~i_clk;
   end
   task automatic wrap_up;
      $display("compared %0d mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   always @(posedge i_clk) begin
      cyc++;
      if (cyc == 5000) begin
         err_count++;
         wrap_up;
      end
   end
   task automatic check(input logic [95:0] got, input logic [95:0] exp);
      n_compared++;
      if (got !== exp) begin
         err_count++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge i_clk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      i_wr <= 1'b1;
      i_addr <= a;
      i_wdata <= d;
      @(posedge i_clk);
      i_wr <= 1'b0;
      @(posedge i_clk);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      i_rd <= 1'b1;
      i_addr <= a;
      @(posedge i_clk);
      i_rd <= 1'b0;
      #1 check(o_rdata, exp);
      @(posedge i_clk);
   endtask
   task automatic pix(input logic [15:0] v, input logic sof, input logic eol,
                      input logic [72:0] exp);
      int n0;
      n0 = n_vid;
      i_pix_valid <= 1'b1;
      i_pix_data <= {6{v}};
      i_pix_sof <= sof;
      i_pix_eol <= eol;
      i_pix_field <= sof;
      @(posedge i_clk iff o_pix_ready);
      i_pix_valid <= 1'b0;
      wait (n_vid != n0);
      check(vid_got, {sof, eol, exp});
      @(posedge i_clk);
   endtask
   task automatic aud(input logic [7:0] ty, input logic [23:0] s,
                      input logic [3:0] ch);
      int n0;
      n0 = n_aud;
      i_aud_valid <= 1'b1;
      i_aud_type <= ty;
      i_aud_sample <= s;
      @(posedge i_clk iff o_aud_ready);
      i_aud_valid <= 1'b0;
      if (ty == 8'h05) begin
         tick(4);
         check(n_aud, n0);
      end else begin
         wait (n_aud != n0);
         check(aud_got, {ch, s});
      end
      @(posedge i_clk);
   endtask
   task automatic t_regs;
      rd(ADDR_CTRL, {24'h0, CTRL_RST});
      rd(ADDR_ACHAN, {28'h0, ACHAN_RST});
      rd(8'h14, 32'h0);
      check({o_video_rst, o_plug_present, o_irq}, 3'h4);
      wr(ADDR_CTRL, 32'h1);
      tick(1);
      check({o_video_rst, o_plug_present}, 2'h1);
      i_sideband_status_word <= 2'h3;
      i_sideband_status_valid <= 1'b1;
      tick(1);
      i_sideband_status_valid <= 1'b0;
      tick(5);
      i_sideband_status_word <= 2'h0;
      tick(6);
      rd(ADDR_STATUS, 32'h7);
      wr(ADDR_EVMASK, 32'h1);
      tick(1);
      check(o_irq, 1'b1);
      wr(ADDR_EVENT, 32'h7);
      tick(1);
      check(o_irq, 1'b0);
      i_source_present <= 1'b0;
      tick(6);
      rd(ADDR_STATUS, 32'h3);
      $display("test regs done");
   endtask
   task automatic t_video;
      int d;
      int n0;
      logic [15:0] v;
      logic [11:0] e;
      slow <= 1'b1;
      for (int b = 0; b < 5; b++) begin
         d = (b == 4) ? 12 : 8 + 2 * b + 2 * (b == 3);
         wr(ADDR_CTRL, {24'h0, (b == 4) ? 2'h0 : 2'(b),
            (b == 4) ? CFMT_422 : CFMT_RGB, b == 4, 3'h1});
         v = 16'hA5C3 & 16'((32'h1 << d) - 1);
         e = 12'(16'(v << (16 - d)) >> 4);
         pix(v, 1'b1, 1'b0, {b == 4, {6{e}}});
      end
      wr(ADDR_CTRL, {24'h0, BPC_16, CFMT_420, 4'h5});
      pix(16'h1234, 1'b1, 1'b1, {1'b0, {6{12'h123}}});
      pix(16'h1234, 1'b0, 1'b0, {1'b0, {2{24'h0, 12'h123}}});
      // park a beat in the output stage, then kill it by video reset
      n0 = n_vid;
      i_pix_valid <= 1'b1;
      tick(1);
      i_pix_valid <= 1'b0;
      i_vid_rst_n <= 1'b0;
      tick(1);
      i_vid_rst_n <= 1'b1;
      tick(3);
      check(o_vid_valid, 1'b0);
      check(n_vid, n0);
      // line parity cleared: chroma kept on the next beat
      pix(16'h1234, 1'b0, 1'b0, {1'b0, {6{12'h123}}});
      rd(ADDR_CTRL, {24'h0, BPC_16, CFMT_420, 4'h5});
      $display("test video done");
   endtask
   task automatic t_audio;
      logic [3:0] ch;
      wr(ADDR_ACHAN, 32'h3);
      aud(8'h05, 24'hBAD, 4'h0);
      for (int k = 0; k < 8; k++) begin
         ch = 4'((k < 5) ? k % 3 : k - 5);
         if (k == 5) begin
            i_aud_rst_n <= 1'b0;
            @(posedge i_clk);
            i_aud_rst_n <= 1'b1;
            @(posedge i_clk);
         end
         // at most one channel frame per 128 clocks
         if (ch == 4'h0)
            tick(128);
         aud(k[0] ? PKT_HBR : PKT_LPCM, 24'h100 + 24'(k), ch);
      end
      rd(ADDR_ACHAN, 32'h3);
      $display("test audio done");
   endtask
   initial begin
      tick(5);
      i_rst_n <= 1'b1;
      i_vid_rst_n <= 1'b1;
      i_aud_rst_n <= 1'b1;
      tick(1);
      t_regs;
      t_video;
      t_audio;
      wrap_up;
   end
endmodule
